/* File: design/tap_defs.svh */
// constants of the boundary-scan test port: codes, lengths, field positions
`ifndef TAP_DEFS_SVH
`define TAP_DEFS_SVH

`define TAP_STATE_W        4
`define TAP_IR_W           3
`define TAP_IR_EXTEST      3'h0
`define TAP_IR_SAMPLE      3'h4
`define TAP_IR_IDCODE      3'h6
`define TAP_IR_BYPASS      3'h7
`define TAP_IR_CAPTURE     3'h1
`define TAP_ID_LEN         32
`define TAP_BS_LEN         98
`define TAP_ID_MARK_BIT    0
`define TAP_ID_PROD_LSB    1
`define TAP_ID_PROD_W      11
`define TAP_ID_PART_LSB    12
`define TAP_ID_PART_W      16
`define TAP_ID_REV_LSB     28
`define TAP_ID_REV_W       4
`define TAP_RESET_EDGES    5
`define TAP_SYNC_STAGES    3
`define TAP_PIN_COUNT      3

`endif

/* File: design/tap_pkg.sv */
// types shared by the boundary-scan test port files
`include "tap_defs.svh"

package tap_pkg;

    // controller states, gray along the data and instruction branches
    typedef enum logic [`TAP_STATE_W-1:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EXIT1_DR = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EXIT2_DR = 4'h4,
        ST_UPD_DR   = 4'hC,
        ST_SEL_IR   = 4'hD,
        ST_CAP_IR   = 4'hF,
        ST_SHIFT_IR = 4'hE,
        ST_EXIT1_IR = 4'hA,
        ST_PAUSE_IR = 4'hB,
        ST_EXIT2_IR = 4'h9,
        ST_UPD_IR   = 4'h8
    } tap_state_t;

    // which data register sits between serial input and output
    typedef enum logic [1:0] {
        SEL_BOUND = 2'h0,
        SEL_ID    = 2'h1,
        SEL_SKIP  = 2'h2
    } dr_sel_t;

endpackage : tap_pkg

/* File: design/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int W = 3                         // number of pins
) (
    input  wire logic         clk,              // system clock
    input  wire logic         reset_n,          // async reset, active low
    input  wire logic [W-1:0] pinIn,            // raw pins, foreign timing
    output logic      [W-1:0] pinLvl            // filtered level, registered
);

    logic [W-1:0] stage1_ff;                    // first stage, read by stage2 only
    logic [W-1:0] stage2_ff;                    // second stage
    logic [W-1:0] stage3_ff;                    // third stage
    logic [W-1:0] level_ff;                     // accepted level
    logic [W-1:0] nxt_level;                    // next accepted level

    // a change counts only once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : gen_filt
            always_comb begin
                nxt_level[g] = (stage2_ff[g] == stage3_ff[g]) ? stage3_ff[g] : level_ff[g];
            end
        end
    endgenerate

    // registers only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            level_ff  <= '0;
        end else begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            level_ff  <= nxt_level;
        end
    end

    assign pinLvl = level_ff;

endmodule : pin_sync

`default_nettype wire

/* File: design/tap_fsm.sv */
// sixteen-state test access port controller
`timescale 1ns/1ns
`default_nettype none

module tap_fsm
    import tap_pkg::*;
(
    input  wire logic  clk,                     // system clock
    input  wire logic  reset_n,                 // async reset, active low
    input  wire logic  step,                    // one-cycle pulse per test clock rise
    input  wire logic  tms,                     // mode select, valid with step
    output tap_state_t state                    // current state, registered
);

    tap_state_t state_ff;                       // present state
    tap_state_t nxt_state;                      // next state

    // transitions follow the mode select taken at each test clock rise
    always_comb begin
        nxt_state = state_ff;
        if (step) begin
            unique case (state_ff)
                ST_RESET:    nxt_state = tms ? ST_RESET    : ST_IDLE;
                ST_IDLE:     nxt_state = tms ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_DR:   nxt_state = tms ? ST_SEL_IR   : ST_CAP_DR;
                ST_CAP_DR:   nxt_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: nxt_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: nxt_state = tms ? ST_UPD_DR   : ST_PAUSE_DR;
                ST_PAUSE_DR: nxt_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: nxt_state = tms ? ST_UPD_DR   : ST_SHIFT_DR;
                ST_UPD_DR:   nxt_state = tms ? ST_SEL_DR   : ST_IDLE;
                ST_SEL_IR:   nxt_state = tms ? ST_RESET    : ST_CAP_IR;
                ST_CAP_IR:   nxt_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: nxt_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: nxt_state = tms ? ST_UPD_IR   : ST_PAUSE_IR;
                ST_PAUSE_IR: nxt_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: nxt_state = tms ? ST_UPD_IR   : ST_SHIFT_IR;
                ST_UPD_IR:   nxt_state = tms ? ST_SEL_DR   : ST_IDLE;
            endcase
        end
    end

    // state register; power-up lands in the reset state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign state = state_ff;

    // helper: count of consecutive rises with mode select high, saturating
    logic [2:0] highRun_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            highRun_ff <= 3'h0;
        end else if (step) begin
            highRun_ff <= !tms ? 3'h0 : ((highRun_ff == 3'h5) ? 3'h5 : highRun_ff + 3'h1);
        end
    end

    property p_five_high_resets;
        @(posedge clk) disable iff (!reset_n)
        (highRun_ff == 3'h5) |-> (state_ff == ST_RESET);
    endproperty
    a_five_high_resets: assert property (p_five_high_resets)
        else $error("five high mode selects did not reach reset state");

    property p_select_to_capture;
        @(posedge clk) disable iff (!reset_n)
        (step && !tms && state_ff == ST_SEL_DR) |=> (state_ff == ST_CAP_DR);
    endproperty
    a_select_to_capture: assert property (p_select_to_capture)
        else $error("select-dr with low mode select did not go to capture");

    property p_hold_without_step;
        @(posedge clk) disable iff (!reset_n)
        !step |=> $stable(state_ff);
    endproperty
    a_hold_without_step: assert property (p_hold_without_step)
        else $error("state moved without a test clock rise");

endmodule : tap_fsm

`default_nettype wire

/* File: design/boundary_scan_test_port.sv */
// boundary-scan test access port: pin sampling, registers and serial path
`timescale 1ns/1ns
`default_nettype none
`include "tap_defs.svh"

// Contract
// - three-bit instruction register, shifted in lsb first
// - code 000: external test through boundary chain
// - code 100: sample/preload, functional path untouched
// - code 110: identification register in serial path
// - code 111: bypass, one test clock delay
// - identification register is 32 fixed bits
// - id: bit0 one, producer, part, revision
// - identification shifts out lsb first
// - bypass is a single flip-flop
// - 98-stage boundary chain, only under test codes
// - sixteen-state controller, data and instruction branches
// - mode select sampled on each test clock rise
// - serial data paced by test clock only
// - test codes put boundary chain in path
// - five high mode selects reach reset state
// - reset state loads identification instruction
// - parallel latches load on fall in Update-DR
module boundary_scan_test_port
    import tap_pkg::*;
#(
    parameter logic [`TAP_ID_PROD_W-1:0] PRODUCER_ID = 11'h0A5, // arbitrary value
    parameter logic [`TAP_ID_PART_W-1:0] PART_ID     = 16'h1234, // arbitrary value
    parameter logic [`TAP_ID_REV_W-1:0]  REVISION_ID = 4'h1      // arbitrary value
) (
    input  wire logic                   clk,          // system clock, 100 MHz
    input  wire logic                   reset_n,      // async reset, active low
    input  wire logic                   tckPin,       // test clock from tester
    input  wire logic                   tmsPin,       // test mode select
    input  wire logic                   tdiPin,       // test data input
    output logic                        tdoOut,       // test data output value
    output logic                        tdoOe,        // test data output enable
    input  wire logic [`TAP_BS_LEN-1:0] pinSample,    // pin levels seen by the chain
    output logic      [`TAP_BS_LEN-1:0] pinDrive,     // latched pattern for the pins
    output logic                        extestActive  // pins take pinDrive, not core
);

    // packed identification value
    localparam logic [`TAP_ID_LEN-1:0] ID_VALUE =
        {REVISION_ID, PART_ID, PRODUCER_ID, 1'b1};

    // instruction to data register decode, shared by datapath and checks
    function automatic dr_sel_t decodeSel(input logic [`TAP_IR_W-1:0] code);
        unique case (code)
            `TAP_IR_EXTEST: decodeSel = SEL_BOUND;
            `TAP_IR_SAMPLE: decodeSel = SEL_BOUND;
            `TAP_IR_IDCODE: decodeSel = SEL_ID;
            default:        decodeSel = SEL_SKIP;
        endcase
    endfunction : decodeSel

    // synchronised pins: bit0 clock, bit1 mode select, bit2 data
    logic [`TAP_PIN_COUNT-1:0] pinLvl;              // filtered levels
    logic                      tckPrev_ff;          // last filtered test clock
    logic                      tckRise;             // test clock rising this cycle
    logic                      tckFall;             // test clock falling this cycle
    tap_state_t                state;               // controller state

    pin_sync #(
        .W      (`TAP_PIN_COUNT)
    ) u_sync (
        .clk    (clk),
        .reset_n(reset_n),
        .pinIn  ({tdiPin, tmsPin, tckPin}),
        .pinLvl (pinLvl)
    );

    // edges of the filtered test clock; all pins share the pipeline delay
    always_comb begin
        tckRise = pinLvl[0] && !tckPrev_ff;
        tckFall = !pinLvl[0] && tckPrev_ff;
    end

    tap_fsm u_fsm (
        .clk    (clk),
        .reset_n(reset_n),
        .step   (tckRise),
        .tms    (pinLvl[1]),
        .state  (state)
    );

    // register state
    logic [`TAP_IR_W-1:0]   instr_ff;               // active instruction
    logic [`TAP_IR_W-1:0]   irShift_ff;             // instruction shift stages
    logic [`TAP_ID_LEN-1:0] idShift_ff;             // identification shift stages
    logic                   skip_ff;                // single-bit skip register
    logic [`TAP_BS_LEN-1:0] bsChain_ff;             // boundary cell chain stages
    logic [`TAP_BS_LEN-1:0] pinDrive_ff;            // parallel output latches
    logic                   tdoOut_ff;              // output data flop
    logic                   tdoOe_ff;               // output enable flop
    logic                   extest_ff;              // external test in force
    logic [`TAP_IR_W-1:0]   nxt_instr;
    logic [`TAP_IR_W-1:0]   nxt_irShift;
    logic [`TAP_ID_LEN-1:0] nxt_idShift;
    logic                   nxt_skip;
    logic [`TAP_BS_LEN-1:0] nxt_bsChain;
    logic [`TAP_BS_LEN-1:0] nxt_pinDrive;
    logic                   nxt_tdoOut;
    logic                   nxt_tdoOe;
    logic                   nxt_extest;
    dr_sel_t                sel;                    // data register in the path
    logic                   tdi;                    // filtered serial input

    // next values of every register of the port except tckPrev_ff
    always_comb begin
        sel          = decodeSel(instr_ff);
        tdi          = pinLvl[2];
        nxt_instr    = instr_ff;
        nxt_irShift  = irShift_ff;
        nxt_idShift  = idShift_ff;
        nxt_skip     = skip_ff;
        nxt_bsChain  = bsChain_ff;
        nxt_pinDrive = pinDrive_ff;
        nxt_tdoOut   = tdoOut_ff;
        nxt_tdoOe    = tdoOe_ff;
        nxt_extest   = (instr_ff == `TAP_IR_EXTEST);
        // rising edge: capture and shift, one bit per test clock
        if (tckRise) begin
            unique case (state)
                ST_CAP_IR:   nxt_irShift = `TAP_IR_CAPTURE;
                ST_SHIFT_IR: nxt_irShift = {tdi, irShift_ff[`TAP_IR_W-1:1]};
                ST_CAP_DR: begin
                    // skip flop has no parallel input, so it keeps its value
                    if (sel == SEL_BOUND) begin
                        nxt_bsChain = pinSample;
                    end else if (sel == SEL_ID) begin
                        nxt_idShift = ID_VALUE;
                    end
                end
                ST_SHIFT_DR: begin
                    unique case (sel)
                        SEL_BOUND: nxt_bsChain = {tdi, bsChain_ff[`TAP_BS_LEN-1:1]};
                        SEL_ID:    nxt_idShift = {tdi, idShift_ff[`TAP_ID_LEN-1:1]};
                        default:   nxt_skip    = tdi;
                    endcase
                end
                default: begin
                end
            endcase
        end
        // falling edge: updates and serial output
        if (tckFall) begin
            nxt_tdoOe = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
            if (state == ST_SHIFT_IR) begin
                nxt_tdoOut = irShift_ff[0];
            end else if (state == ST_SHIFT_DR) begin
                unique case (sel)
                    SEL_BOUND: nxt_tdoOut = bsChain_ff[0];
                    SEL_ID:    nxt_tdoOut = idShift_ff[0];
                    default:   nxt_tdoOut = skip_ff;
                endcase
            end
            if (state == ST_UPD_IR) begin
                nxt_instr = irShift_ff;
            end
            if (state == ST_UPD_DR && sel == SEL_BOUND) begin
                nxt_pinDrive = bsChain_ff;
            end
        end
        // the reset state forces the identification instruction
        if (state == ST_RESET) begin
            nxt_instr = `TAP_IR_IDCODE;
        end
    end

    // registers only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tckPrev_ff  <= 1'b0;
            instr_ff    <= `TAP_IR_IDCODE;
            irShift_ff  <= '0;
            idShift_ff  <= '0;
            skip_ff     <= 1'b0;
            bsChain_ff  <= '0;
            pinDrive_ff <= '0;
            tdoOut_ff   <= 1'b0;
            tdoOe_ff    <= 1'b0;
            extest_ff   <= 1'b0;
        end else begin
            tckPrev_ff  <= pinLvl[0];
            instr_ff    <= nxt_instr;
            irShift_ff  <= nxt_irShift;
            idShift_ff  <= nxt_idShift;
            skip_ff     <= nxt_skip;
            bsChain_ff  <= nxt_bsChain;
            pinDrive_ff <= nxt_pinDrive;
            tdoOut_ff   <= nxt_tdoOut;
            tdoOe_ff    <= nxt_tdoOe;
            extest_ff   <= nxt_extest;
        end
    end

    assign tdoOut       = tdoOut_ff;
    assign tdoOe        = tdoOe_ff;
    assign pinDrive     = pinDrive_ff;
    assign extestActive = extest_ff;

    // checks

    property p_reset_loads_idcode;
        @(posedge clk) disable iff (!reset_n)
        (state == ST_RESET) |=> (instr_ff == `TAP_IR_IDCODE);
    endproperty
    a_reset_loads_idcode: assert property (p_reset_loads_idcode)
        else $error("reset state did not load identification instruction");

    // judged on the registers themselves, so a broken decode cannot hide
    property p_unassigned_bypass;
        @(posedge clk) disable iff (!reset_n)
        (tckRise && state == ST_SHIFT_DR && instr_ff != `TAP_IR_EXTEST &&
         instr_ff != `TAP_IR_SAMPLE && instr_ff != `TAP_IR_IDCODE) |=>
            (skip_ff == $past(tdi)) && $stable(bsChain_ff) && $stable(idShift_ff);
    endproperty
    a_unassigned_bypass: assert property (p_unassigned_bypass)
        else $error("unassigned instruction did not select skip flop");

    property p_oe_only_shift;
        @(posedge clk) disable iff (!reset_n)
        $rose(tdoOe_ff) |-> $past(tckFall) &&
            ($past(state) == ST_SHIFT_DR || $past(state) == ST_SHIFT_IR);
    endproperty
    a_oe_only_shift: assert property (p_oe_only_shift)
        else $error("output enabled outside a shift state");

    property p_latch_only_update;
        @(posedge clk) disable iff (!reset_n)
        !$stable(pinDrive_ff) |-> $past(tckFall) && $past(state) == ST_UPD_DR;
    endproperty
    a_latch_only_update: assert property (p_latch_only_update)
        else $error("parallel latches changed outside update on fall");

    property p_chain_only_test;
        @(posedge clk) disable iff (!reset_n)
        !$stable(bsChain_ff) |-> $past(tckRise) && $past(sel) == SEL_BOUND;
    endproperty
    a_chain_only_test: assert property (p_chain_only_test)
        else $error("boundary chain moved without a test instruction");

    property p_capture_pins;
        @(posedge clk) disable iff (!reset_n)
        (tckRise && state == ST_CAP_DR && sel == SEL_BOUND) |=>
            (bsChain_ff == $past(pinSample)) && $stable(skip_ff);
    endproperty
    a_capture_pins: assert property (p_capture_pins)
        else $error("capture did not load pin levels");

    property p_id_first_bit;
        @(posedge clk) disable iff (!reset_n)
        (tckRise && state == ST_CAP_DR && sel == SEL_ID) |=>
            (idShift_ff == ID_VALUE) && idShift_ff[`TAP_ID_MARK_BIT];
    endproperty
    a_id_first_bit: assert property (p_id_first_bit)
        else $error("identification value not captured with bit0 set");

    property p_skip_one_period;
        @(posedge clk) disable iff (!reset_n)
        (tckRise && state == ST_SHIFT_DR && sel == SEL_SKIP) |=>
            (skip_ff == $past(tdi));
    endproperty
    a_skip_one_period: assert property (p_skip_one_period)
        else $error("skip flop did not take serial input");

    property p_sample_keeps_core;
        @(posedge clk) disable iff (!reset_n)
        (instr_ff == `TAP_IR_SAMPLE) |=> !extest_ff;
    endproperty
    a_sample_keeps_core: assert property (p_sample_keeps_core)
        else $error("sample/preload disturbed the functional path");

    property p_ir_lsb_first;
        @(posedge clk) disable iff (!reset_n)
        (tckRise && state == ST_SHIFT_IR) |=>
            (irShift_ff[`TAP_IR_W-1] == $past(tdi)) &&
            (irShift_ff[0] == $past(irShift_ff[1]));
    endproperty
    a_ir_lsb_first: assert property (p_ir_lsb_first)
        else $error("instruction bits not shifted lsb first");

endmodule : boundary_scan_test_port

`default_nettype wire

/* File: sim/tap_tester.sv */
// tester model: makes the test clock and walks the port controller
`timescale 1ns/1ns
`default_nettype none

module tap_tester (
    input  wire logic clk,    // system clock, paces the test clock
    input  wire logic tdoOut, // serial data from the port
    input  wire logic tdoOe,  // its enable, high while driven
    output logic      tck,    // test clock, still low between scans
    output logic      tms,    // mode select
    output logic      tdi     // serial data to the port
);
    // idle: clock low, mode select high keeps the port in reset
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 80 ns period, entered at a falling clk edge; inputs held 40 ns
    // either side of the rise; read late in the high phase, since the port
    // answers about 45 ns after a fall
    task automatic tick(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (4) @(negedge clk);
        q = tdoOe ? tdoOut : 1'bz; // undriven line floats
        tck = 1'b0;
    endtask : tick

    // five high mode selects reach reset from any state, then park in idle
    task automatic park();
        logic q;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : park

    // instruction scan from idle; cap returns the bits shifted out
    task automatic instr(input logic [2:0] code, output logic [2:0] cap);
        logic q;
        tick(1'b1, 1'b0, q);
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < 3; i++) tick(i == 2, code[i], cap[i]);
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
    endtask : instr

    // data scan of n bits from idle, with update; gap is the line after exit
    task automatic data(input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic gap);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
        tick(1'b1, 1'b0, gap);
        tick(1'b0, 1'b0, q);
    endtask : data
endmodule : tap_tester
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench of the boundary-scan test port
`timescale 1ns/1ns
`default_nettype none
`include "tap_defs.svh"

module tb_top;
    import tap_pkg::*;
    localparam logic [10:0]  PROD = 11'h2F1;  // arbitrary value
    localparam logic [15:0]  PART = 16'h5AC3; // arbitrary value
    localparam logic [3:0]   REV  = 4'hA;     // arbitrary value
    localparam logic [31:0]  IDV  = {REV, PART, PROD, 1'b1};
    localparam logic [97:0]  PA   = {2'h2, 96'hF0E1D2C3B4A5968778695A4B};
    localparam logic [97:0]  PB   = {2'h1, 96'h123456789ABCDEF0FEDCBA98};
    logic                    clk, reset_n, tck, tms, tdi, tdoOut, tdoOe, extestActive;
    logic [`TAP_BS_LEN-1:0]  pinSample, pinDrive;
    logic [127:0]            d1, d2;  // data shifted out
    logic [2:0]              cap;     // instruction capture bits
    logic                    g, q;    // line after exit, spare read
    int                      err_count, comparisons;

    boundary_scan_test_port #(.PRODUCER_ID(PROD), .PART_ID(PART), .REVISION_ID(REV)) dut_u (
        .clk(clk), .reset_n(reset_n), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi),
        .tdoOut(tdoOut), .tdoOe(tdoOe), .pinSample(pinSample), .pinDrive(pinDrive),
        .extestActive(extestActive));
    tap_tester tester_u (.clk(clk), .tdoOut(tdoOut), .tdoOe(tdoOe), .tck(tck), .tms(tms),
        .tdi(tdi));

    always #5 clk = ~clk;

    // compare and count; four-state so an unknown matches only the same unknown
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // verdict and end of run
    task automatic conclude();
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // identification straight after reset; line floats outside shifting
    task automatic ident_after_reset();
        check("idleOe", tdoOe, 1'b0);
        tester_u.tick(1'b0, 1'b0, q);
        tester_u.data(32, '0, d1, g);
        check("idcode", d1, IDV);
        check("exitLine", g, 1'bz);
    endtask : ident_after_reset

    // bypass and unassigned codes: one period delay, flop kept at capture
    task automatic skip_codes();
        logic [2:0] codes [5];
        codes = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5};
        foreach (codes[k]) begin
            tester_u.instr(codes[k], cap);
            check("irCapture", cap, 3'h1);
            tester_u.data(8, 8'h96, d1, g);
            check("skipDelay", d1[7:1], 7'h16);
            tester_u.data(8, 8'h3C, d2, g);
            check("skipKeep", d2[7:0], {7'h3C, 1'b1});
        end
    endtask : skip_codes

    // sample/preload: chain captures pins, latches preload, pins stay functional
    task automatic sample_preload();
        pinSample = PA;
        tester_u.instr(3'h4, cap);
        check("extestOff", extestActive, 1'b0);
        tester_u.data(98, PB, d1, g);
        check("sampled", d1[97:0], PA);
        check("preload", pinDrive, PB);
    endtask : sample_preload

    // external test: pins take the latched pattern shifted in
    task automatic external_test();
        pinSample = PB;
        tester_u.instr(3'h0, cap);
        check("extestOn", extestActive, 1'b1);
        tester_u.data(98, PA, d1, g);
        check("extCapture", d1[97:0], PB);
        check("extDrive", pinDrive, PA);
    endtask : external_test

    // mode select reset from mid-shift restores identification
    task automatic mode_reset();
        tester_u.tick(1'b1, 1'b0, q);
        tester_u.tick(1'b0, 1'b0, q);
        tester_u.tick(1'b0, 1'b0, q);
        tester_u.tick(1'b0, 1'b1, q);
        tester_u.park();
        check("resetExtest", extestActive, 1'b0);
        tester_u.data(32, '0, d1, g);
        check("resetIdcode", d1, IDV);
        // the way out passes Update-DR after two shifts (tdi 1, then 0)
        check("latchHeld", pinDrive, {2'h1, PB[97:2]});
        tester_u.instr(3'h6, cap);
        tester_u.data(32, '0, d1, g);
        check("loadIdcode", d1, IDV);
    endtask : mode_reset

    // main sequence: reset, settle the synchroniser, run scenarios
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        pinSample = '0;
        err_count = 0;
        comparisons = 0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (5) @(negedge clk);
        ident_after_reset();
        skip_codes();
        sample_preload();
        external_test();
        mode_reset();
        conclude();
    end

    // watchdog: scenarios need about 42 us of test clock
    initial begin
        #150000;
        err_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
